// [include/spi_defs.vh]
// constants for the serial port interrupt and event identification block
`ifndef SPI_DEFS_VH
`define SPI_DEFS_VH
`define SPI_OFS_IER        3'h1
`define SPI_OFS_EIR        3'h2
`define SPI_OFS_LSR        3'h5
`define SPI_OFS_MSR        3'h6
`define SPI_OFS_DATA       3'h0
`define SPI_IE_RX          0
`define SPI_IE_TX          1
`define SPI_IE_LS          2
`define SPI_IE_MS          3
`define SPI_IE_DMA         4
`define SPI_IE_TXEMP       5
`define SPI_IER_RST        8'h00
`define SPI_EIR_RST        8'h01
`define SPI_CODE_NONE      4'h1
`define SPI_CODE_LS        4'h6
`define SPI_CODE_RX        4'h4
`define SPI_CODE_TMO       4'hC
`define SPI_CODE_TX        4'h2
`define SPI_CODE_MS        4'h0
`define SPI_CHAR_TIMES     3'h4
`endif

// [core/spi_edge_flag.v]
// sticky event flag: hardware set wins over clear
`timescale 1ns/1ns
module spi_edge_flag (
    input  wire clk_sys_i,
    input  wire srst_i,
    input  wire ce_i,
    input  wire set_i,
    input  wire clr_i,
    output reg  flag_o
);
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            flag_o <= 1'b0;
        end else if (ce_i) begin
            if (set_i)
                flag_o <= 1'b1;
            else if (clr_i)
                flag_o <= 1'b0;
        end
    end
endmodule

// [core/spi_irq_events.v]
// interrupt enable and event identification logic of a serial port
// Functional notes
// - bit0 gates rx level and timeout, legacy
// - bit1 gates tx low level, legacy
// - bit2 gates link status, default off
// - bit3 gates modem status, legacy
// - bits 7-4 cleared outside extended mode
// - extended bit0 enables rx threshold/timeout
// - extended bit1 enables tx low/empty
// - extended bit4 enables dma terminal count
// - extended bit5 enables tx empty; 7,6 reserved
// - consumer ir bit2 adds tx underrun
// - offset 02h read events, write fifo control
// - legacy four levels, frozen during read
// - legacy bit0 low means pending
// - legacy bit3 marks rx timeout, fifos on
// - legacy bits 7,6 show fifos enabled
// - link status highest, cleared by status read
// - rx level second, level driven
// - rx timeout second, four character times
// - tx low third, cleared by read or write
// - modem status lowest, line edges, status read
// - extended bits are raw pending flags
// - extended read clears dma flag when dma_legacy_i is set
// - legacy format only when select bit 0
`timescale 1ns/1ns
`include "spi_defs.vh"
module spi_irq_events (
    input  wire       clk_sys_i,
    input  wire       srst_i,
    input  wire       ce_i,
    input  wire [2:0] addr_i,
    input  wire       rd_i,
    input  wire       wr_i,
    input  wire [7:0] wdata_i,
    input  wire       extended_mode_select_i,
    input  wire       consumer_ir_i,
    input  wire       dma_legacy_i,
    input  wire       dma_enabled_i,
    input  wire       rx_level_i,
    input  wire       rx_char_time_i,
    input  wire       rx_nonempty_i,
    input  wire       rx_fifo_access_i,
    input  wire       tx_low_i,
    input  wire       tx_empty_i,
    input  wire       line_error_i,
    input  wire       tx_underrun_i,
    input  wire       dma_tc_i,
    input  wire       cts_i,
    input  wire       dsr_i,
    input  wire       dcd_i,
    input  wire       ri_i,
    output reg  [7:0] rdata_o,
    output reg  [7:0] interrupt_enable_o,
    output reg        fifo_enable_o,
    output reg        irq_o
);
    reg  [3:0] modem_s1;
    reg  [3:0] modem_s2;
    reg  [3:0] modem_d;
    reg  [7:0] interrupt_enable;
    reg        fifo_en;
    reg  [3:0] shown_code;
    reg  [2:0] tmo_cnt;
    reg  [3:0] next_code;
    reg  [7:0] eir_val;
    reg        tmo_flag;
    reg        tx_flag;
    reg        tx_low_q;
    wire       ls_flag;
    wire       ms_flag;
    wire       dma_flag;
    wire       legacy = ~extended_mode_select_i;
    wire       rd_eir = ce_i & rd_i & (addr_i == `SPI_OFS_EIR);
    wire       rd_lsr = ce_i & rd_i & (addr_i == `SPI_OFS_LSR);
    wire       rd_msr = ce_i & rd_i & (addr_i == `SPI_OFS_MSR);
    wire       rd_dat = ce_i & rd_i & (addr_i == `SPI_OFS_DATA);
    wire       wr_dat = ce_i & wr_i & (addr_i == `SPI_OFS_DATA);
    wire       ms_edge;
    wire       ls_set;

    // modem lines arrive from pins
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            modem_s1 <= 4'h0;
            modem_s2 <= 4'h0;
            modem_d  <= 4'h0;
        end else if (ce_i) begin
            modem_s1 <= {ri_i, dcd_i, dsr_i, cts_i};
            modem_s2 <= modem_s1;
            modem_d  <= modem_s2;
        end
    end

    assign ms_edge = |(modem_s2[2:0] ^ modem_d[2:0])
                   | (modem_s2[3] & ~modem_d[3]);
    // underrun joins link status in consumer ir
    assign ls_set = line_error_i | (consumer_ir_i & tx_underrun_i);

    spi_edge_flag u_ls (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .set_i     (ls_set),
        .clr_i     (rd_lsr),
        .flag_o    (ls_flag)
    );
    spi_edge_flag u_ms (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .set_i     (ms_edge),
        .clr_i     (rd_msr),
        .flag_o    (ms_flag)
    );
    // dma flag cleared by extended event read when dma_legacy_i is set
    spi_edge_flag u_dma (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .ce_i      (ce_i),
        .set_i     (dma_tc_i & dma_enabled_i),
        .clr_i     (rd_eir & extended_mode_select_i & dma_legacy_i),
        .flag_o    (dma_flag)
    );

    // register writes
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            interrupt_enable <= `SPI_IER_RST;
            fifo_en          <= 1'b0;
        end else if (ce_i) begin
            if (wr_i && addr_i == `SPI_OFS_IER) begin
                interrupt_enable[3:0] <= wdata_i[3:0];
                if (extended_mode_select_i)
                    interrupt_enable[5:4] <= wdata_i[5:4];
            end
            if (legacy)
                interrupt_enable[7:4] <= 4'h0;
            // write at 02h is fifo control
            if (wr_i && addr_i == `SPI_OFS_EIR)
                fifo_en <= wdata_i[0];
        end
    end

    // timeout after four idle character times
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            tmo_cnt  <= 3'h0;
            tmo_flag <= 1'b0;
        end else if (ce_i) begin
            if (!rx_nonempty_i || rx_fifo_access_i || !fifo_en) begin
                tmo_cnt <= 3'h0;
            end else if (rx_char_time_i && tmo_cnt != `SPI_CHAR_TIMES) begin
                tmo_cnt <= tmo_cnt + 3'h1;
            end
            if (rx_char_time_i && tmo_cnt == `SPI_CHAR_TIMES - 3'h1
                && rx_nonempty_i && !rx_fifo_access_i && fifo_en)
                tmo_flag <= 1'b1;
            else if (rd_dat)
                tmo_flag <= 1'b0;
        end
    end

    // tx low: set on new low level, cleared by read or data write
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            tx_flag  <= 1'b0;
            tx_low_q <= 1'b0;
        end else if (ce_i) begin
            tx_low_q <= tx_low_i;
            if (tx_low_i && !tx_low_q)
                tx_flag <= 1'b1;
            else if (wr_dat || (rd_eir && legacy
                     && shown_code == `SPI_CODE_TX))
                tx_flag <= 1'b0;
        end
    end

    always @* begin
        next_code = `SPI_CODE_NONE;
        if (ms_flag && interrupt_enable[`SPI_IE_MS])
            next_code = `SPI_CODE_MS;
        if (tx_flag && interrupt_enable[`SPI_IE_TX])
            next_code = `SPI_CODE_TX;
        if (tmo_flag && interrupt_enable[`SPI_IE_RX])
            next_code = `SPI_CODE_TMO;
        if (rx_level_i && interrupt_enable[`SPI_IE_RX])
            next_code = `SPI_CODE_RX;
        if (ls_flag && interrupt_enable[`SPI_IE_LS])
            next_code = `SPI_CODE_LS;
        // timeout bit only with fifos on
        if (!fifo_en)
            next_code[3] = 1'b0;
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            shown_code <= `SPI_CODE_NONE;
        end else if (ce_i) begin
            if (!rd_eir)
                shown_code <= next_code;
        end
    end

    always @* begin
        if (legacy) begin
            // a frozen timeout code must not outlive fifos
            eir_val = {fifo_en, fifo_en, 2'b00,
                       shown_code[3] & fifo_en, shown_code[2:0]};
        end else begin
            eir_val = {2'b00, tx_empty_i, dma_flag, ms_flag,
                       ls_flag, tx_low_i | tx_empty_i,
                       rx_level_i | tmo_flag};
        end
    end

    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o            <= 8'h00;
            interrupt_enable_o <= `SPI_IER_RST;
            fifo_enable_o      <= 1'b0;
            irq_o              <= 1'b0;
        end else if (ce_i) begin
            interrupt_enable_o <= interrupt_enable;
            fifo_enable_o      <= fifo_en;
            if (rd_i) begin
                case (addr_i)
                    `SPI_OFS_IER: rdata_o <= interrupt_enable;
                    `SPI_OFS_EIR: rdata_o <= eir_val;
                    default:      rdata_o <= 8'h00;
                endcase
            end
            if (legacy)
                irq_o <= ~shown_code[0];
            else
                irq_o <= |(eir_val[5:0] & interrupt_enable[5:0]);
        end
    end
endmodule

// [verif/spi_irq_events_asserts.sv]
// assertion checker for the serial port event block
`timescale 1ns/1ns
module spi_irq_events_asserts (
    input wire       clk_sys_i,
    input wire       srst_i,
    input wire       ce_i,
    input wire [2:0] addr_i,
    input wire       rd_i,
    input wire       wr_i,
    input wire [7:0] wdata_i,
    input wire       extended_mode_select_i,
    input wire       consumer_ir_i,
    input wire [7:0] rdata_o,
    input wire [7:0] interrupt_enable_o,
    input wire       fifo_enable_o,
    input wire       irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    wire eir_rd = ce_i && rd_i && addr_i == 3'h2 && !extended_mode_select_i;
    // enable copy lags the register by one edge, hence two legacy cycles
    ier_upper_clear_a: assert property (
        (ce_i && !extended_mode_select_i) [*2]
        |=> interrupt_enable_o[7:4] == 4'h0)
        else $error("upper enables set in legacy mode");
    ier_ext_write_a: assert property (
        ce_i && wr_i && addr_i == 3'h1 && extended_mode_select_i ##1 ce_i
        |=> interrupt_enable_o[5:0] == $past(wdata_i[5:0], 2))
        else $error("extended enable write lost");
    fifo_ctl_write_a: assert property (
        ce_i && wr_i && addr_i == 3'h2 && !consumer_ir_i ##1 ce_i
        |=> fifo_enable_o == $past(wdata_i[0], 2))
        else $error("fifo enable not taken from write");
    eir_fixed_bits_a: assert property (
        eir_rd |=> rdata_o[5:4] == 2'h0
        && rdata_o[7:6] == {2{fifo_enable_o}})
        else $error("event byte upper bits wrong");
    tmo_bit_off_a: assert property (
        eir_rd ##1 !fifo_enable_o |-> !rdata_o[3])
        else $error("timeout bit set with fifos off");
    code_legal_a: assert property (
        eir_rd |=> rdata_o[3:0] inside {4'h1, 4'h6, 4'h4, 4'hC, 4'h2, 4'h0})
        else $error("illegal event code");
    irq_quiet_a: assert property (
        (interrupt_enable_o == 8'h00) [*3] |-> !irq_o)
        else $error("request with all enables off");
    unmapped_zero_a: assert property (
        ce_i && rd_i && addr_i inside {3'h3, 3'h4, 3'h7} |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    ce_freeze_a: assert property (
        !ce_i && !srst_i
        |=> $stable(interrupt_enable_o) && $stable(irq_o))
        else $error("state moved with clock enable low");
    irq_code_match_a: assert property (
        eir_rd |=> irq_o == !rdata_o[0])
        else $error("request disagrees with pending flag");
    ier_reset_value_a: assert property (
        $fell(srst_i) |-> interrupt_enable_o == 8'h00 && !irq_o)
        else $error("enables not cleared by reset");
endmodule
bind spi_irq_events spi_irq_events_asserts spi_irq_events_asserts_i (.*);

// [verif/spi_host_model.sv]
// host cpu model issuing register reads and writes
`timescale 1ns/1ns
module spi_host_model (
    input  wire       clk_sys_i,
    input  wire [7:0] rdata_i,
    output reg  [2:0] addr_o = 3'h0,
    output reg        rd_o = 1'b0,
    output reg        wr_o = 1'b0,
    output reg  [7:0] wdata_o = 8'h00
);
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(negedge clk_sys_i);
            addr_o = a;
            wdata_o = d;
            wr_o = 1'b1;
            @(negedge clk_sys_i);
            wr_o = 1'b0;
            // stale data must not look valid
            wdata_o = ~d;
        end
    endtask
    task rd(input [2:0] a, output [7:0] d);
        begin
            @(negedge clk_sys_i);
            addr_o = a;
            rd_o = 1'b1;
            @(negedge clk_sys_i);
            rd_o = 1'b0;
            d = rdata_i;
        end
    endtask
endmodule

// [verif/spi_irq_events_bench.sv]
// self-checking bench for the serial port event block
`timescale 1ns/1ns
module spi_irq_events_bench;
    reg        clk_sys_i = 1'b0;
    reg        srst_i = 1'b1;
    reg        ce_i = 1'b1;
    reg        extended_mode_select_i = 1'b0;
    reg        rx_level_i = 1'b0;
    reg        rx_char_time_i = 1'b0;
    reg        rx_nonempty_i = 1'b0;
    reg        tx_low_i = 1'b0;
    reg        line_error_i = 1'b0;
    reg        dma_tc_i = 1'b0;
    reg        ri_i = 1'b0;
    reg        cts_i = 1'b0;
    reg        dsr_i = 1'b0;
    reg        dcd_i = 1'b0;
    reg        consumer_ir_i = 1'b0;
    reg        tx_empty_i = 1'b0;
    reg        tx_underrun_i = 1'b0;
    reg        rx_fifo_access_i = 1'b0;
    wire [2:0] addr_i;
    wire       rd_i;
    wire       wr_i;
    wire [7:0] wdata_i;
    wire [7:0] rdata_o;
    wire [7:0] interrupt_enable_o;
    wire       fifo_enable_o;
    wire       irq_o;
    reg  [7:0] got;
    integer    error_cnt = 0;
    integer    num_checks = 0;
    integer    cyc = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    spi_irq_events spi_irq_events_i (.*,
        .dma_legacy_i(extended_mode_select_i),
        .dma_enabled_i(extended_mode_select_i));
    spi_host_model spi_host_model_i (.clk_sys_i(clk_sys_i),
        .rdata_i(rdata_o), .addr_o(addr_i), .rd_o(rd_i), .wr_o(wr_i),
        .wdata_o(wdata_i));
    task chk(input [7:0] g, input [7:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("BAD t=%0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task rc(input [2:0] a, input [7:0] e);
        begin
            spi_host_model_i.rd(a, got);
            chk(got, e);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task char_times(input integer n);
        repeat (n) begin
            rx_char_time_i = 1'b1;
            tick(1);
            rx_char_time_i = 1'b0;
            tick(1);
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d errors %0d", num_checks, error_cnt);
            if (error_cnt == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // whole sequence needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
    end
    initial begin
        tick(20);
        srst_i = 1'b0;
        rc(3'h1, 8'h00);
        rc(3'h2, 8'h01);
        spi_host_model_i.wr(3'h1, 8'hFF);
        rc(3'h1, 8'h0F);
        rx_level_i = 1'b1;
        line_error_i = 1'b1;
        tick(1);
        line_error_i = 1'b0;
        tick(4);
        chk({7'h00, irq_o}, 8'h01);
        rc(3'h2, 8'h06);
        spi_host_model_i.rd(3'h5, got);
        rc(3'h2, 8'h04);
        rx_level_i = 1'b0;
        tick(2);
        rc(3'h2, 8'h01);
        tx_low_i = 1'b1;
        tick(3);
        rc(3'h2, 8'h02);
        rc(3'h2, 8'h01);
        ri_i = 1'b1;
        tick(6);
        rc(3'h2, 8'h00);
        spi_host_model_i.rd(3'h6, got);
        rc(3'h2, 8'h01);
        ri_i = 1'b0;
        tick(6);
        rc(3'h2, 8'h01);
        dcd_i = 1'b1;
        tick(6);
        rc(3'h2, 8'h00);
        spi_host_model_i.rd(3'h6, got);
        rc(3'h7, 8'h00);
        spi_host_model_i.wr(3'h2, 8'h01);
        rc(3'h2, 8'hC1);
        rx_nonempty_i = 1'b1;
        char_times(3);
        rx_fifo_access_i = 1'b1;
        tick(1);
        rx_fifo_access_i = 1'b0;
        char_times(3);
        rc(3'h2, 8'hC1);
        char_times(1);
        tick(2);
        rc(3'h2, 8'hCC);
        spi_host_model_i.rd(3'h0, got);
        rc(3'h2, 8'hC1);
        ce_i = 1'b0;
        tick(3);
        ce_i = 1'b1;
        extended_mode_select_i = 1'b1;
        spi_host_model_i.wr(3'h1, 8'h10);
        rc(3'h1, 8'h10);
        dma_tc_i = 1'b1;
        tick(1);
        dma_tc_i = 1'b0;
        tick(3);
        chk({7'h00, irq_o}, 8'h01);
        spi_host_model_i.rd(3'h2, got);
        chk(got & 8'h10, 8'h10);
        spi_host_model_i.rd(3'h2, got);
        chk(got & 8'h10, 8'h00);
        tx_low_i = 1'b0;
        spi_host_model_i.wr(3'h1, 8'h20);
        tx_empty_i = 1'b1;
        tick(3);
        chk({7'h00, irq_o}, 8'h01);
        rc(3'h2, 8'h22);
        tx_empty_i = 1'b0;
        tick(3);
        chk({7'h00, irq_o}, 8'h00);
        consumer_ir_i = 1'b1;
        spi_host_model_i.wr(3'h1, 8'h04);
        tx_underrun_i = 1'b1;
        tick(1);
        tx_underrun_i = 1'b0;
        tick(3);
        chk({7'h00, irq_o}, 8'h01);
        rc(3'h2, 8'h04);
        spi_host_model_i.rd(3'h5, got);
        tick(2);
        chk({7'h00, irq_o}, 8'h00);
        consumer_ir_i = 1'b0;
        tx_underrun_i = 1'b1;
        tick(1);
        tx_underrun_i = 1'b0;
        tick(3);
        chk({7'h00, irq_o}, 8'h00);
        spi_host_model_i.wr(3'h1, 8'h3F);
        rc(3'h1, 8'h3F);
        extended_mode_select_i = 1'b0;
        tick(2);
        rc(3'h1, 8'h0F);
        stop_test;
    end
endmodule
